// ### fps_apb_bfm.sv
// APB master model standing in for software on the register bus.
// Assumes each call starts just after a rising edge of clk.
`timescale 1ns/1ps
module fps_apb_bfm (
	// Clock
	input wire logic clk,
	// Request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	// Answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h0;
	end

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Request stands until ready is seen high at a rising edge
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		// Idle edge so a following call never re-drives in this step
		@(posedge clk);
	endtask : xfer
endmodule : fps_apb_bfm

// ### fps_chk.sv
// Checker for the fuse sequencer bus port and status outputs.
// Assumes binding to fps_seq by its top-level port names.
`timescale 1ns/1ps
module fps_chk (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Status
	input wire logic IRQ,
	input wire logic BUSY
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	wire logic rd_cmd = PREADY && !PWRITE && PADDR == fps_pkg::CMD_OFS;

	a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("ready missing after one wait");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
		else $error("error outside an access");
	a_err_unmapped: assert property (PREADY && PADDR > fps_pkg::DECST_OFS |-> PSLVERR)
		else $error("unmapped address accepted");
	a_busy_min: assert property ($rose(BUSY) |-> BUSY [*4])
		else $error("cycle ended too soon");
	a_cmd_busy: assert property (rd_cmd && $past(BUSY) && BUSY |-> PRDATA != 32'h0)
		else $error("command zero while busy");
	a_cmd_idle: assert property (rd_cmd && !$past(BUSY) && !BUSY |-> PRDATA == 32'h0)
		else $error("command nonzero while idle");
	a_reset_quiet: assert property ($rose(RST_B) |-> !IRQ && !BUSY && !PREADY)
		else $error("outputs active out of reset");
endmodule : fps_chk

// ### fps_fuse_mem.sv
// One-time programmable fuse array model: 32 words of 32 bits.
// Assumes writes only ever set bits; read data are registered.
`timescale 1ns/1ps
module fps_fuse_mem (
	// Clock
	input wire logic clk,
	// Burn port
	input wire logic we,
	input wire logic [fps_pkg::AW-1:0] addr,
	input wire logic [31:0] wdata,
	// Read port
	output logic [31:0] rdata
);

	// Virgin fuses read as zero; reset never clears them
	logic [31:0] mem_q [fps_pkg::WORDS] = '{default: 32'h0000_0000};

	// RQ14 bits only ever set
	always_ff @(posedge clk) begin
		if (we) begin
			mem_q[addr] <= mem_q[addr] | wdata;
		end
	end

	always_ff @(posedge clk) begin
		rdata <= mem_q[addr];
	end

endmodule : fps_fuse_mem

// ### fps_pkg.sv
// Shared constants for the fuse program/read sequencer.
// Assumes a 32-bit APB slave with a 12-bit byte address window.
package fps_pkg;

	// Register byte offsets
	localparam logic [11:0] RD0_OFS = 12'h000;
	localparam logic [11:0] WR0_OFS = 12'h01C;
	localparam logic [11:0] RDK_OFS = 12'h038;
	localparam logic [11:0] WRK_OFS = 12'h098;
	localparam logic [11:0] TIMING_OFS = 12'h0F8;
	localparam logic [11:0] OPCODE_OFS = 12'h0FC;
	localparam logic [11:0] CMD_OFS = 12'h104;
	localparam logic [11:0] RAW_OFS = 12'h108;
	localparam logic [11:0] MSK_OFS = 12'h10C;
	localparam logic [11:0] ENA_OFS = 12'h110;
	localparam logic [11:0] CLR_OFS = 12'h114;
	localparam logic [11:0] VOLT_OFS = 12'h118;
	localparam logic [11:0] DECST_OFS = 12'h11C;

	// Word counts and storage geometry
	localparam int BLK0_WORDS = 7;
	localparam int KEY_WORDS = 24;
	localparam int WORDS = 32;
	localparam int AW = 5;

	// Opcodes and commands
	localparam logic [15:0] OPC_PROGRAM = 16'h5A5A;
	localparam logic [15:0] OPC_READ = 16'h5AA5;
	localparam logic [1:0] CMD_IDLE = 2'h0;
	localparam logic [1:0] CMD_READ = 2'h1;
	localparam logic [1:0] CMD_PROGRAM = 2'h2;

	// Timing register fields and reset values
	localparam int TA_LSB = 0;
	localparam int TB_LSB = 8;
	localparam int VDIV_LSB = 0;
	localparam logic [15:0] TIMING_RST = 16'hFFFA;
	localparam logic [7:0] VDIV_RST = 8'h34;

	// Done flag positions
	localparam int IRQ_READ = 0;
	localparam int IRQ_PROG = 1;

	// Protect bits in config word 0, coding scheme in config word 6
	localparam int WPROT_KEY1 = 7;
	localparam int WPROT_KEY2 = 8;
	localparam int WPROT_KEY3 = 9;
	localparam int CS_WORD = 6;
	localparam int CS_LSB = 0;
	localparam logic [1:0] CS_34 = 2'h1;
	localparam logic [1:0] CS_REP = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BURN = 2'b01,
		ST_FETCH = 2'b11,
		ST_DONE = 2'b10
	} fps_state_e;

endpackage : fps_pkg

// ### fps_seq.sv
// Overview of operation
// RQ1: Software stages only bits it wants burned.
// RQ2: Opcode 0x5A5A then command 0x2 burns.
// RQ3: Burn end clears command, raises program-done.
// RQ4: Opcode 0x5AA5 then command 0x1 reads back.
// RQ5: Read end clears command, raises read-done.
// RQ6: Software clears staged bits after read-back.
// RQ7: Software sets timing count A per clock.
// RQ8: Software sets timing count B per clock.
// RQ9: Software sets burn voltage divider per clock.
// RQ10: Raw flags: program bit 1, read bit 0.
// RQ11: Writing one to clear bit clears flag.
// RQ12: Enable bits gate flags onto interrupt.
// RQ13: Masked status is raw AND enable.
// RQ14: Separate burns keep earlier programmed bits.
// RQ15: Software keeps burn cycles few.
// RQ16: Software burns protect bit promptly.
// RQ17: Software never restages programmed bits.
// RQ18: Eight read words per key block.
// RQ19: Valid width follows coding scheme; rest zero.
// RQ20: Read words show decoded key values.
// RQ21: Scheme selector 00/11 none, 01 3/4, 10 repeat.
// RQ22: Protected key block never changes again; code takes protect bits from the last read-back, cleared by reset.
// RQ23: Command stays nonzero until cycle ends.
//
// Fuse controller program and read-back sequencer, APB slave.
// Assumes a single 25 MHz clock and a synchronous active-low reset.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module fps_seq (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Interrupt and status
	output logic IRQ,
	output logic BUSY
);

	// Word indexes of the register regions
	localparam logic [9:0] RD0_I = fps_pkg::RD0_OFS[11:2];
	localparam logic [9:0] WR0_I = fps_pkg::WR0_OFS[11:2];
	localparam logic [9:0] RDK_I = fps_pkg::RDK_OFS[11:2];
	localparam logic [9:0] WRK_I = fps_pkg::WRK_OFS[11:2];
	localparam logic [9:0] KEY_N = 10'(fps_pkg::KEY_WORDS);
	localparam logic [9:0] BLK0_N = 10'(fps_pkg::BLK0_WORDS);

	// Decoded view of one 256-bit stored block
	function automatic logic [255:0] fps_decode(input logic [255:0] enc, input logic [1:0] cs);
		logic [255:0] dec;
		dec = 256'h0;
		if (cs == fps_pkg::CS_34) begin
			for (int b = 0; b < 24; b++) begin
				dec[8*b +: 8] = enc[8*(8*(b/6) + (b%6)) +: 8];
			end
		end else if (cs == fps_pkg::CS_REP) begin
			dec[127:0] = enc[127:0];
		end else begin
			dec = enc;
		end
		return dec;
	endfunction : fps_decode

	// Storage id of an APB word index inside a region
	function automatic logic [4:0] fps_id(input logic [9:0] idx, input logic [9:0] base,
		input logic key);
		logic [9:0] rel;
		rel = idx - base;
		return key ? 5'(rel + 10'd8) : rel[4:0];
	endfunction : fps_id

	// State
	fps_pkg::fps_state_e state_q;
	fps_pkg::fps_state_e state_d;
	logic [31:0] stage_q [fps_pkg::WORDS];
	logic [31:0] shadow_q [fps_pkg::WORDS];
	logic [15:0] timing_q;
	logic [7:0] vdiv_q;
	logic [15:0] opcode_q;
	logic [1:0] cmd_q;
	logic [1:0] raw_q;
	logic [1:0] ena_q;
	logic [4:0] word_q;
	logic [8:0] cnt_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;
	logic busy_q;
	logic [31:0] mem_rdata;

	// APB decode
	wire access = PSEL & PENABLE;
	wire rd_phase = access & ~pready_q & ~PWRITE;
	wire wr_take = access & pready_q & PWRITE;
	wire [9:0] idx = PADDR[11:2];
	wire in_rd0 = (idx >= RD0_I) && (idx < RD0_I + BLK0_N);
	wire in_wr0 = (idx >= WR0_I) && (idx < WR0_I + BLK0_N);
	wire in_rdk = (idx >= RDK_I) && (idx < RDK_I + KEY_N);
	wire in_wrk = (idx >= WRK_I) && (idx < WRK_I + KEY_N);
	wire is_timing = PADDR == fps_pkg::TIMING_OFS;
	wire is_opcode = PADDR == fps_pkg::OPCODE_OFS;
	wire is_cmd = PADDR == fps_pkg::CMD_OFS;
	wire is_raw = PADDR == fps_pkg::RAW_OFS;
	wire is_msk = PADDR == fps_pkg::MSK_OFS;
	wire is_ena = PADDR == fps_pkg::ENA_OFS;
	wire is_clr = PADDR == fps_pkg::CLR_OFS;
	wire is_volt = PADDR == fps_pkg::VOLT_OFS;
	wire is_decst = PADDR == fps_pkg::DECST_OFS;
	wire mapped = in_rd0 | in_wr0 | in_rdk | in_wrk | is_timing | is_opcode | is_cmd |
		is_raw | is_msk | is_ena | is_clr | is_volt | is_decst;
	wire [4:0] rd_id = in_rd0 ? fps_id(idx, RD0_I, 1'b0) : fps_id(idx, RDK_I, 1'b1);
	wire [4:0] wr_id = in_wr0 ? fps_id(idx, WR0_I, 1'b0) : fps_id(idx, WRK_I, 1'b1);
	wire stage_wr = wr_take & (in_wr0 | in_wrk);

	// RQ21 scheme selector
	wire [1:0] cs = shadow_q[fps_pkg::CS_WORD][fps_pkg::CS_LSB +: 2];
	wire [15:0] wr_dis = shadow_q[0][15:0];

	// RQ20 decoded key view
	logic [31:0] view_w [fps_pkg::WORDS];
	genvar gn, gk;
	generate
		for (gk = 0; gk < 8; gk++) begin : g_cfg
			assign view_w[gk] = shadow_q[gk];
		end
		for (gn = 1; gn < 4; gn++) begin : g_key
			wire [255:0] enc;
			wire [255:0] dec;
			for (gk = 0; gk < 8; gk++) begin : g_pack
				assign enc[32*gk +: 32] = shadow_q[8*gn + gk];
			end
			// RQ19 invalid bits zero
			assign dec = fps_decode(enc, cs);
			// RQ18 word k bits
			for (gk = 0; gk < 8; gk++) begin : g_view
				assign view_w[8*gn + gk] = dec[32*gk +: 32];
			end
		end
	endgenerate

	// RQ13 masked status view
	wire [1:0] masked = raw_q & ena_q;
	wire [31:0] rd_mux =
		(in_rd0 | in_rdk) ? view_w[rd_id] :
		(in_wr0 | in_wrk) ? stage_q[wr_id] :
		is_timing ? {16'h0000, timing_q} :
		is_opcode ? {16'h0000, opcode_q} :
		is_cmd ? {30'h0, cmd_q} :
		is_raw ? {30'h0, raw_q} :
		is_msk ? {30'h0, masked} :
		is_ena ? {30'h0, ena_q} :
		is_volt ? {24'h000000, vdiv_q} :
		32'h0000_0000;

	// RQ2 program start check
	wire start_prog = wr_take & is_cmd & (state_q == fps_pkg::ST_IDLE) &
		(PWDATA[1:0] == fps_pkg::CMD_PROGRAM) & (PWDATA[31:2] == 30'h0) &
		(opcode_q == fps_pkg::OPC_PROGRAM);
	// RQ4 read start check
	wire start_read = wr_take & is_cmd & (state_q == fps_pkg::ST_IDLE) &
		(PWDATA[1:0] == fps_pkg::CMD_READ) & (PWDATA[31:2] == 30'h0) &
		(opcode_q == fps_pkg::OPC_READ);

	// Step lengths from software timing counts
	wire [7:0] t_a = timing_q[fps_pkg::TA_LSB +: 8];
	wire [7:0] t_b = timing_q[fps_pkg::TB_LSB +: 8];
	wire [8:0] burn_len = {1'b0, t_a} + {1'b0, t_b};
	wire [8:0] read_len = (t_a == 8'h00) ? 9'h001 : {1'b0, t_a};
	wire burn_hit = (state_q == fps_pkg::ST_BURN) && (cnt_q == burn_len);
	wire fetch_hit = (state_q == fps_pkg::ST_FETCH) && (cnt_q == read_len);
	wire last_word = word_q == 5'h1F;

	// RQ22 protected key blocks
	wire prot = (word_q[4:3] == 2'h1) ? wr_dis[fps_pkg::WPROT_KEY1] :
		(word_q[4:3] == 2'h2) ? wr_dis[fps_pkg::WPROT_KEY2] :
		(word_q[4:3] == 2'h3) ? wr_dis[fps_pkg::WPROT_KEY3] : 1'b0;
	wire [31:0] burn_data = prot ? 32'h0000_0000 : stage_q[word_q];

	// Done events
	wire [1:0] done_set = (state_q == fps_pkg::ST_DONE) ?
		((cmd_q == fps_pkg::CMD_PROGRAM) ? 2'b10 : 2'b01) : 2'b00;
	wire [1:0] clr_bits = (wr_take & is_clr) ? PWDATA[1:0] : 2'b00;

	fps_fuse_mem u_mem (
		.clk(CLK),
		.we(burn_hit),
		.addr(word_q),
		.wdata(burn_data),
		.rdata(mem_rdata)
	);

	// Next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			fps_pkg::ST_IDLE: begin
				if (start_prog) begin
					state_d = fps_pkg::ST_BURN;
				end else if (start_read) begin
					state_d = fps_pkg::ST_FETCH;
				end
			end
			fps_pkg::ST_BURN: begin
				if (burn_hit && last_word) begin
					state_d = fps_pkg::ST_DONE;
				end
			end
			fps_pkg::ST_FETCH: begin
				if (fetch_hit && last_word) begin
					state_d = fps_pkg::ST_DONE;
				end
			end
			fps_pkg::ST_DONE: begin
				state_d = fps_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			state_q <= fps_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Word walk and step counter
	always_ff @(posedge CLK) begin
		if (!RST_B || state_q == fps_pkg::ST_IDLE) begin
			word_q <= 5'h00;
			cnt_q <= 9'h000;
		end else if (burn_hit || fetch_hit) begin
			word_q <= word_q + 5'h01;
			cnt_q <= 9'h000;
		end else begin
			cnt_q <= cnt_q + 9'h001;
		end
	end

	// RQ23 command held
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			cmd_q <= fps_pkg::CMD_IDLE;
		end else if (start_prog || start_read) begin
			cmd_q <= PWDATA[1:0];
		end else if (state_q == fps_pkg::ST_DONE) begin
			// RQ3 RQ5 command cleared
			cmd_q <= fps_pkg::CMD_IDLE;
		end
	end

	// RQ10 RQ11 sticky done flags
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			raw_q <= 2'b00;
		end else begin
			raw_q <= (raw_q & ~clr_bits) | done_set;
		end
	end

	// RQ12 RQ13 gated interrupt
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(raw_q & ena_q);
		end
	end

	// Control registers
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			timing_q <= fps_pkg::TIMING_RST;
			vdiv_q <= fps_pkg::VDIV_RST;
			opcode_q <= 16'h0000;
			ena_q <= 2'b00;
		end else if (wr_take) begin
			if (is_timing) begin
				timing_q <= PWDATA[15:0];
			end
			if (is_volt) begin
				vdiv_q <= PWDATA[fps_pkg::VDIV_LSB +: 8];
			end
			if (is_opcode) begin
				opcode_q <= PWDATA[15:0];
			end
			if (is_ena) begin
				ena_q <= PWDATA[1:0];
			end
		end
	end

	// Staging and read-back words
	generate
		for (gk = 0; gk < fps_pkg::WORDS; gk++) begin : g_words
			always_ff @(posedge CLK) begin
				if (!RST_B) begin
					stage_q[gk] <= 32'h0000_0000;
				end else if (stage_wr && wr_id == 5'(gk)) begin
					stage_q[gk] <= PWDATA;
				end
			end
			always_ff @(posedge CLK) begin
				if (!RST_B) begin
					shadow_q[gk] <= 32'h0000_0000;
				end else if (fetch_hit && word_q == 5'(gk)) begin
					shadow_q[gk] <= mem_rdata;
				end
			end
		end
	endgenerate

	// Busy flag registered onto its pin
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= state_d != fps_pkg::ST_IDLE;
		end
	end

	// APB answer, one wait state
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (access && !pready_q) begin
			pready_q <= 1'b1;
			pslverr_q <= ~mapped;
			if (rd_phase) begin
				prdata_q <= rd_mux;
			end
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign IRQ = irq_q;
	assign BUSY = busy_q;

endmodule : fps_seq

// ### tb.sv
// Self-checking bench for the fuse sequencer.
// Assumes the fuse array starts blank and the bus model drives APB.
`timescale 1ns/1ps
module tb;
	logic CLK;
	logic RST_B;
	logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, BUSY;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rv;
	logic re;
	int bad_count = 0;
	int num_checks = 0;

	fps_seq i_dut (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.IRQ(IRQ), .BUSY(BUSY));
	fps_apb_bfm i_bfm (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
		.paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));

	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end

	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_bfm.xfer(1'b1, a, d, rv, re);
	endtask : wr

	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		i_bfm.xfer(1'b0, a, 32'h0, rv, re);
		chk($sformatf("reg %h", a), rv, e);
	endtask : rc

	// Start a cycle, then poll the command register back to zero
	task automatic run(input logic [15:0] opc, input logic [31:0] c);
		int n;
		n = 0;
		wr(fps_pkg::OPCODE_OFS, {16'h0000, opc});
		wr(fps_pkg::CMD_OFS, c);
		rc(fps_pkg::CMD_OFS, c);
		chk("busy run", {31'h0, BUSY}, 32'h1);
		do begin
			i_bfm.xfer(1'b0, fps_pkg::CMD_OFS, 32'h0, rv, re);
			n++;
		end while (rv !== 32'h0 && n < 200);
		chk("cmd end", rv, 32'h0);
		chk("busy end", {31'h0, BUSY}, 32'h0);
	endtask : run

	// Stage, burn, read back, unstage
	task automatic burn(input logic [11:0] a, input logic [31:0] d);
		wr(a, d);
		run(fps_pkg::OPC_PROGRAM, 32'h2);
		run(fps_pkg::OPC_READ, 32'h1);
		wr(a, 32'h0);
	endtask : burn

	task automatic t_reset();
		rc(fps_pkg::TIMING_OFS, {16'h0000, fps_pkg::TIMING_RST});
		rc(fps_pkg::VOLT_OFS, {24'h0, fps_pkg::VDIV_RST});
		rc(12'h200, 32'h0);
		chk("slverr", {31'h0, re}, 32'h1);
		// Short timing keeps the burn sweep brief
		wr(fps_pkg::TIMING_OFS, 32'h0101);
		wr(fps_pkg::VOLT_OFS, 32'h50);
		rc(fps_pkg::VOLT_OFS, 32'h50);
		wr(fps_pkg::CMD_OFS, 32'h2);
		rc(fps_pkg::CMD_OFS, 32'h0);
	endtask : t_reset

	task automatic t_flags();
		wr(fps_pkg::ENA_OFS, 32'h3);
		wr(fps_pkg::WRK_OFS, 32'hA5);
		run(fps_pkg::OPC_PROGRAM, 32'h2);
		rc(fps_pkg::RAW_OFS, 32'h2);
		chk("irq", {31'h0, IRQ}, 32'h1);
		rc(fps_pkg::MSK_OFS, 32'h2);
		wr(fps_pkg::ENA_OFS, 32'h1);
		rc(fps_pkg::MSK_OFS, 32'h0);
		chk("irq", {31'h0, IRQ}, 32'h0);
		wr(fps_pkg::CLR_OFS, 32'h2);
		rc(fps_pkg::RAW_OFS, 32'h0);
		run(fps_pkg::OPC_READ, 32'h1);
		rc(fps_pkg::RAW_OFS, 32'h1);
		chk("irq", {31'h0, IRQ}, 32'h1);
		wr(fps_pkg::CLR_OFS, 32'h1);
		rc(fps_pkg::RAW_OFS, 32'h0);
		rc(fps_pkg::RDK_OFS, 32'hA5);
		wr(fps_pkg::WRK_OFS, 32'h0);
	endtask : t_flags

	task automatic t_keys();
		burn(fps_pkg::WRK_OFS, 32'h5A00);
		rc(fps_pkg::RDK_OFS, 32'h5AA5);
		burn(12'h0B4, 32'h80000000);
		rc(12'h054, 32'h80000000);
		burn(12'h0C0, 32'h44332211);
		rc(12'h060, 32'h44332211);
		burn(fps_pkg::WR0_OFS, 32'h80);
		burn(12'h09C, 32'h1);
		rc(12'h03C, 32'h0);
	endtask : t_keys

	task automatic t_scheme();
		burn(12'h034, 32'h1);
		rc(12'h054, 32'h0);
		rc(12'h05C, 32'h22110000);
		rc(12'h060, 32'h00004433);
		burn(12'h034, 32'h2);
		rc(12'h060, 32'h44332211);
	endtask : t_scheme

	// Mid-run reset: registers back to defaults, fuses keep their bits
	task automatic t_rerun();
		RST_B <= 1'b0;
		repeat (2) @(posedge CLK);
		RST_B <= 1'b1;
		@(posedge CLK);
		rc(fps_pkg::TIMING_OFS, {16'h0000, fps_pkg::TIMING_RST});
		rc(fps_pkg::RAW_OFS, 32'h0);
		rc(fps_pkg::RDK_OFS, 32'h0);
		wr(fps_pkg::TIMING_OFS, 32'h0101);
		run(fps_pkg::OPC_READ, 32'h1);
		rc(fps_pkg::RAW_OFS, 32'h1);
		rc(fps_pkg::RDK_OFS, 32'h5AA5);
	endtask : t_rerun

	task automatic stop_test();
		if (bad_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	initial begin
		RST_B = 1'b0;
		repeat (2) @(posedge CLK);
		RST_B <= 1'b1;
		@(posedge CLK);
		t_reset();
		t_flags();
		t_keys();
		t_scheme();
		t_rerun();
		stop_test();
	end

	initial begin
		repeat (40000) @(posedge CLK);
		bad_count++;
		stop_test();
	end
endmodule : tb

bind fps_seq fps_chk i_chk (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .IRQ(IRQ), .BUSY(BUSY));
